// file: rtl/cpdi_map.svh
// Constants of the control pin dimming link
`ifndef CPDI_MAP_SVH
`define CPDI_MAP_SVH
`define CPD_CLK_NS 25
`define CPD_CYC_UP(t) (((t) + `CPD_CLK_NS - 1) / `CPD_CLK_NS)
`define CPD_CYC_DN(t) ((t) / `CPD_CLK_NS)
`define CPD_SHUT_NS 2500000
`define CPD_WIN_NS 1000000
`define CPD_DELAY_NS 100000
`define CPD_DETECT_NS 260000
`define CPD_ACK_NS 512000
`define CPD_IDLE_NS 360000
`define CPD_H_WAIT_NS 120000
`define CPD_H_ENTRY_NS 300000
`define CPD_H_SHUT_NS 3000000
`define CPD_H_GAP_NS 400000
`define CPD_H_SHORT_NS 10000
`define CPD_H_LONG_NS 30000
`define CPD_PWM_NS 100000
`define CPD_DELAY_CYC `CPD_CYC_UP(`CPD_DELAY_NS)
`define CPD_SHORT_CYC `CPD_CYC_UP(`CPD_H_SHORT_NS)
`define CPD_LONG_CYC `CPD_CYC_UP(`CPD_H_LONG_NS)
`define CPD_PWM_CYC `CPD_CYC_UP(`CPD_PWM_NS)
`define CPD_FULL_MV 8'hc8
`define CPD_DEV_ADDR 8'h72
`define CPD_LEVEL_DEFAULT 5'h1f
`define CPD_FILT_SHIFT 6
`define CPD_ROUND 16'h0080
`define CPD_SEG1_END 5'h0c
`define CPD_SEG2_END 5'h17
`define CPD_LAST_BIT 4'hf
`define CPD_ACK_BIT 7
`define CPD_SUB_HI 6
`define CPD_SUB_LO 5
`define CPD_LVL_HI 4
`define CPD_REG_CMD 12'h000
`define CPD_REG_DUTY 12'h004
`define CPD_REG_STATUS 12'h008
`define CPD_OP_PWM 3'h1
`define CPD_OP_ONEWIRE 3'h2
`define CPD_OP_SEND 3'h3
`define CPD_OP_SHUT 3'h4
`define CPD_DUTY_RESET 9'h100
`endif

// file: rtl/cpdi_pkg.sv
// Types of the control pin dimming link
package cpdi_pkg;
    typedef logic [4:0] cpdi_level_type;
    typedef logic [7:0] cpdi_mv_type;
    typedef logic [16:0] cpdi_cnt_type;
    typedef enum logic [1:0] {
        DEV_SHUTDOWN, DEV_DETECT, DEV_PWM, DEV_ONEWIRE
    } cpdi_dev_state_type;
    typedef enum logic [3:0] {
        H_OFF, H_SHUT, H_WAIT, H_ENTRY, H_READY,
        H_START, H_BITHI, H_BITLO, H_GAP, H_PWM
    } cpdi_host_state_type;
endpackage : cpdi_pkg

// file: rtl/cpdi_if.sv
// Open-drain control line between host and device
`timescale 1ns/10ps
interface cpdi_if;
    logic line;
    logic hostOut;
    logic hostOe;
    logic devOut;
    logic devOe;
    // Pull-up: high unless a driver pulls low
    assign line = !((hostOe && !hostOut) || (devOe && !devOut));
    modport device (input line, output devOut, output devOe);
    modport host (input line, output hostOut, output hostOe);
endinterface : cpdi_if

// file: rtl/cpdi_level_map.sv
// Level code to reference millivolt mapping
`timescale 1ns/10ps
`include "cpdi_map.svh"
module cpdi_level_map (
    input cpdi_pkg::cpdi_level_type code,
    output cpdi_pkg::cpdi_mv_type mv
);
    import cpdi_pkg::*;
    cpdi_mv_type c8;
    assign c8 = {3'h0, code};
    always_comb begin
        if (code == 5'h00) begin
            mv = 8'h00;
        end else if (code <= `CPD_SEG1_END) begin
            mv = 8'h03 * c8 + 8'h02;
        end else if (code <= `CPD_SEG2_END) begin
            mv = 8'h06 * c8 - 8'h22;
        end else begin
            mv = 8'h0c * c8 - 8'hac;
        end
    end
endmodule : cpdi_level_map

// file: rtl/cpdi_device.sv
// Device end: control pin decoder and brightness reference
//
// Chosen here: the low-pass filter and rounding of the brightness reference.
`timescale 1ns/10ps
`include "cpdi_map.svh"
module cpdi_device #(
    parameter int unsigned SHUT_CYC = `CPD_CYC_UP(`CPD_SHUT_NS),
    parameter int unsigned WIN_CYC = `CPD_CYC_DN(`CPD_WIN_NS),
    parameter int unsigned DETECT_CYC = `CPD_CYC_UP(`CPD_DETECT_NS),
    parameter int unsigned ACK_CYC = `CPD_CYC_DN(`CPD_ACK_NS),
    parameter int unsigned IDLE_CYC = `CPD_CYC_UP(`CPD_IDLE_NS)
) (
    input logic clk,
    input logic rst_n,
    cpdi_if.device link,
    output logic powerSwitchEn_r,
    output logic oneWireMode_r,
    output cpdi_pkg::cpdi_level_type levelCode_r,
    output cpdi_pkg::cpdi_mv_type refLevel_r
);
    import cpdi_pkg::*;

    cpdi_dev_state_type state_r;
    cpdi_dev_state_type state_nxt;
    logic linePrev_r;
    logic rise;
    logic fall;
    cpdi_cnt_type lowCnt_r;
    cpdi_cnt_type highCnt_r;
    cpdi_cnt_type sinceRise_r;
    cpdi_cnt_type bitHigh_r;
    cpdi_cnt_type ackCnt_r;
    logic entryArm_r;
    logic entryHit;
    logic shutHit;
    logic inBit_r;
    logic ackOn_r;
    logic rxOn;
    logic [3:0] bitCnt_r;
    logic [15:0] shift_r;
    logic [15:0] word;
    logic bitDone;
    logic bitVal;
    logic frameOk;
    cpdi_mv_type mapMv;
    cpdi_mv_type target;
    logic [15:0] acc_r;
    logic [15:0] accRound;
    logic signed [16:0] diff;
    logic signed [16:0] step;

    // ------------------------------------------------------------
    // Line edges and phase timers
    // ------------------------------------------------------------
    assign rise = link.line && !linePrev_r;
    assign fall = !link.line && linePrev_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            linePrev_r <= 1'b0;
        end else begin
            linePrev_r <= link.line;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowCnt_r <= '0;
        end else if (link.line) begin
            lowCnt_r <= '0;
        end else if (lowCnt_r != 17'(SHUT_CYC)) begin
            lowCnt_r <= lowCnt_r + 17'h00001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            highCnt_r <= '0;
        end else if (!link.line) begin
            highCnt_r <= '0;
        end else if (highCnt_r != 17'(IDLE_CYC)) begin
            highCnt_r <= highCnt_r + 17'h00001;
        end
    end

    // ------------------------------------------------------------
    // Enable, shutdown and mode selection
    // ------------------------------------------------------------
    assign shutHit = !link.line && lowCnt_r == 17'(SHUT_CYC);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sinceRise_r <= '0;
        end else if (state_r == DEV_SHUTDOWN) begin
            sinceRise_r <= '0;
        end else if (sinceRise_r != 17'(WIN_CYC)) begin
            sinceRise_r <= sinceRise_r + 17'h00001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            entryArm_r <= 1'b0;
        end else if (state_r == DEV_SHUTDOWN || rise) begin
            entryArm_r <= 1'b0;
        end else if (fall) begin
            entryArm_r <= sinceRise_r >= 17'(`CPD_DELAY_CYC);
        end
    end

    assign entryHit = state_r == DEV_DETECT && !link.line && entryArm_r
        && lowCnt_r == 17'(DETECT_CYC)
        && sinceRise_r < 17'(WIN_CYC);

    always_comb begin
        state_nxt = state_r;
        if (state_r != DEV_SHUTDOWN && shutHit) begin
            state_nxt = DEV_SHUTDOWN;
        end else begin
            unique case (state_r)
                DEV_SHUTDOWN: begin
                    if (rise) begin
                        state_nxt = DEV_DETECT;
                    end
                end
                DEV_DETECT: begin
                    if (entryHit) begin
                        state_nxt = DEV_ONEWIRE;
                    end else if (sinceRise_r == 17'(WIN_CYC)) begin
                        state_nxt = DEV_PWM;
                    end
                end
                DEV_PWM, DEV_ONEWIRE: begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= DEV_SHUTDOWN;
            powerSwitchEn_r <= 1'b0;
            oneWireMode_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            powerSwitchEn_r <= state_nxt != DEV_SHUTDOWN;
            oneWireMode_r <= state_nxt == DEV_ONEWIRE;
        end
    end

    // ------------------------------------------------------------
    // One-wire bit receiver
    // ------------------------------------------------------------
    assign rxOn = state_r == DEV_ONEWIRE && !ackOn_r;
    assign bitDone = rxOn && rise && inBit_r;
    assign bitVal = lowCnt_r <= bitHigh_r;
    assign word = {shift_r[14:0], bitVal};
    assign frameOk = bitDone && bitCnt_r == `CPD_LAST_BIT
        && word[15:8] == `CPD_DEV_ADDR
        && word[`CPD_SUB_HI:`CPD_SUB_LO] == 2'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inBit_r <= 1'b0;
            bitCnt_r <= 4'h0;
            shift_r <= 16'h0000;
            bitHigh_r <= '0;
        end else if (!rxOn) begin
            inBit_r <= 1'b0;
            bitCnt_r <= 4'h0;
        end else if (link.line && highCnt_r == 17'(IDLE_CYC)) begin
            inBit_r <= 1'b0;
            bitCnt_r <= 4'h0;
        end else if (fall && inBit_r) begin
            bitHigh_r <= highCnt_r;
        end else if (rise) begin
            inBit_r <= 1'b1;
            if (inBit_r) begin
                shift_r <= word;
                if (bitCnt_r == `CPD_LAST_BIT) begin
                    bitCnt_r <= 4'h0;
                    inBit_r <= 1'b0;
                end else begin
                    bitCnt_r <= bitCnt_r + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Level register and acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            levelCode_r <= `CPD_LEVEL_DEFAULT;
        end else if (frameOk) begin
            levelCode_r <= word[`CPD_LVL_HI:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ackOn_r <= 1'b0;
            ackCnt_r <= '0;
        end else if (state_r == DEV_SHUTDOWN) begin
            ackOn_r <= 1'b0;
        end else if (frameOk && word[`CPD_ACK_BIT]) begin
            ackOn_r <= 1'b1;
            ackCnt_r <= '0;
        end else if (ackOn_r) begin
            if (ackCnt_r == 17'(ACK_CYC - 1)) begin
                ackOn_r <= 1'b0;
            end else begin
                ackCnt_r <= ackCnt_r + 17'h00001;
            end
        end
    end

    assign link.devOe = ackOn_r;
    assign link.devOut = 1'b0;

    // ------------------------------------------------------------
    // Reference gating and low-pass filter
    // ------------------------------------------------------------
    cpdi_level_map uMap (
        .code(levelCode_r),
        .mv(mapMv)
    );

    always_comb begin
        unique case (state_r)
            DEV_SHUTDOWN: target = 8'h00;
            DEV_ONEWIRE: target = mapMv;
            DEV_DETECT, DEV_PWM: begin
                target = link.line ? `CPD_FULL_MV : 8'h00;
            end
        endcase
    end

    always_comb begin
        diff = $signed({1'b0, target, 8'h00}) - $signed({1'b0, acc_r});
        step = diff >>> `CPD_FILT_SHIFT;
    end

    assign accRound = acc_r + `CPD_ROUND;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_r <= 16'h0000;
            refLevel_r <= 8'h00;
        end else begin
            acc_r <= acc_r + step[15:0];
            refLevel_r <= accRound[15:8];
        end
    end
endmodule : cpdi_device

// file: rtl/cpdi_host.sv
// Host end: APB-controlled driver of the control pin
`timescale 1ns/10ps
`include "cpdi_map.svh"
module cpdi_host #(
    parameter int unsigned WAIT_CYC = `CPD_CYC_UP(`CPD_H_WAIT_NS),
    parameter int unsigned ENTRY_CYC = `CPD_CYC_UP(`CPD_H_ENTRY_NS),
    parameter int unsigned SHUT_CYC = `CPD_CYC_UP(`CPD_H_SHUT_NS),
    parameter int unsigned GAP_CYC = `CPD_CYC_UP(`CPD_H_GAP_NS)
) (
    input logic clk,
    input logic rst_n,
    cpdi_if.host link,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata_r,
    output logic pready_r,
    output logic pslverr_r
);
    import cpdi_pkg::*;

    cpdi_host_state_type state_r;
    cpdi_host_state_type state_nxt;
    cpdi_cnt_type cnt_r;
    cpdi_cnt_type phaseLen;
    logic [15:0] shift_r;
    logic [3:0] bit_r;
    logic ackReq_r;
    logic ackSeen_r;
    logic refused_r;
    logic [8:0] duty_r;
    logic [11:0] pwmCnt_r;
    logic [20:0] prod;
    logic pwmLow;
    logic drvLow;
    logic cmdGo;
    logic okOp;
    logic [2:0] op;
    logic busy;
    logic [1:0] mode;
    logic [31:0] rdata;
    logic mapped;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign op = pwdata[2:0];
    assign cmdGo = psel && penable && pready_r && pwrite
        && paddr == `CPD_REG_CMD;
    assign mapped = paddr == `CPD_REG_CMD || paddr == `CPD_REG_DUTY
        || paddr == `CPD_REG_STATUS;
    assign busy = !(state_r inside {H_OFF, H_READY, H_PWM});
    assign mode = state_r == H_PWM ? 2'h1
        : (state_r inside {H_READY, H_START, H_BITHI, H_BITLO, H_GAP})
        ? 2'h2 : 2'h0;

    always_comb begin
        rdata = 32'h00000000;
        if (paddr == `CPD_REG_DUTY) begin
            rdata = {23'h000000, duty_r};
        end else if (paddr == `CPD_REG_STATUS) begin
            rdata = {26'h0000000, refused_r, link.line, mode,
                ackSeen_r, busy};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel && penable && !pready_r;
            prdata_r <= rdata;
            pslverr_r <= psel && penable && !pready_r && !mapped;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            duty_r <= `CPD_DUTY_RESET;
        end else if (psel && penable && pready_r && pwrite
            && paddr == `CPD_REG_DUTY) begin
            duty_r <= pwdata[8:0];
        end
    end

    always_comb begin
        unique case (op)
            `CPD_OP_PWM, `CPD_OP_ONEWIRE: okOp = state_r == H_OFF;
            `CPD_OP_SEND: okOp = state_r == H_READY;
            `CPD_OP_SHUT: okOp = !busy;
            default: okOp = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            refused_r <= 1'b0;
        end else if (cmdGo) begin
            refused_r <= !okOp;
        end
    end

    // ------------------------------------------------------------
    // Line sequencer
    // ------------------------------------------------------------
    always_comb begin
        phaseLen = 17'(`CPD_SHORT_CYC);
        if ((state_r == H_BITHI) == shift_r[15]) begin
            if (state_r != H_START) begin
                phaseLen = 17'(`CPD_LONG_CYC);
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            H_OFF: begin
                if (cmdGo && okOp && op == `CPD_OP_PWM) begin
                    state_nxt = H_PWM;
                end else if (cmdGo && okOp && op == `CPD_OP_ONEWIRE) begin
                    state_nxt = H_WAIT;
                end else if (cmdGo && okOp && op == `CPD_OP_SHUT) begin
                    state_nxt = H_SHUT;
                end
            end
            H_SHUT: if (cnt_r == 17'(SHUT_CYC - 1)) state_nxt = H_OFF;
            H_WAIT: if (cnt_r == 17'(WAIT_CYC - 1)) state_nxt = H_ENTRY;
            H_ENTRY: begin
                if (cnt_r == 17'(ENTRY_CYC - 1)) begin
                    state_nxt = H_GAP;
                end
            end
            H_READY: begin
                if (cmdGo && okOp && op == `CPD_OP_SEND) begin
                    state_nxt = H_START;
                end else if (cmdGo && okOp && op == `CPD_OP_SHUT) begin
                    state_nxt = H_SHUT;
                end
            end
            H_START: begin
                if (cnt_r == 17'(`CPD_SHORT_CYC - 1)) state_nxt = H_BITHI;
            end
            H_BITHI: if (cnt_r == phaseLen - 17'h00001) state_nxt = H_BITLO;
            H_BITLO: begin
                if (cnt_r == phaseLen - 17'h00001) begin
                    state_nxt = bit_r == `CPD_LAST_BIT ? H_GAP : H_BITHI;
                end
            end
            H_GAP: begin
                if (link.line && cnt_r >= 17'(GAP_CYC - 1)) begin
                    state_nxt = H_READY;
                end
            end
            H_PWM: begin
                if (cmdGo && okOp && op == `CPD_OP_SHUT) state_nxt = H_SHUT;
            end
            default: state_nxt = H_OFF;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= H_OFF;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r || (state_r == H_GAP && !link.line)) begin
                cnt_r <= '0;
            end else if (cnt_r != '1) begin
                cnt_r <= cnt_r + 17'h00001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_r <= 16'h0000;
            bit_r <= 4'h0;
            ackReq_r <= 1'b0;
            ackSeen_r <= 1'b0;
        end else if (state_r == H_READY && state_nxt == H_START) begin
            shift_r <= {`CPD_DEV_ADDR, pwdata[15:8]};
            ackReq_r <= pwdata[8 + `CPD_ACK_BIT];
            bit_r <= 4'h0;
            ackSeen_r <= 1'b0;
        end else if (state_r == H_BITLO && state_nxt != H_BITLO) begin
            shift_r <= {shift_r[14:0], 1'b0};
            bit_r <= bit_r + 4'h1;
        end else if (state_r == H_GAP && ackReq_r && !link.line) begin
            ackSeen_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // PWM generator and open-drain driver
    // ------------------------------------------------------------
    assign prod = {12'h000, duty_r} * 21'(`CPD_PWM_CYC);
    assign pwmLow = {1'b0, pwmCnt_r} >= prod[20:8];

    always_ff @(posedge clk) begin
        if (!rst_n || state_r != H_PWM) begin
            pwmCnt_r <= 12'h000;
        end else if (pwmCnt_r == 12'(`CPD_PWM_CYC - 1)) begin
            pwmCnt_r <= 12'h000;
        end else begin
            pwmCnt_r <= pwmCnt_r + 12'h001;
        end
    end

    assign drvLow = (state_nxt inside {H_OFF, H_SHUT, H_ENTRY, H_START,
        H_BITLO}) || (state_nxt == H_PWM && pwmLow);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.hostOe <= 1'b1;
            link.hostOut <= 1'b0;
        end else begin
            link.hostOe <= drvLow;
            link.hostOut <= 1'b0;
        end
    end
endmodule : cpdi_host

// file: verification/cpdi_properties.sv
// Concurrent checks on the control pin link
`timescale 1ns/10ps
`include "cpdi_map.svh"
module cpdi_properties #(
    parameter int unsigned SHUT_CYC = 5000,
    parameter int unsigned ACK_CYC = 200
) (
    input logic clk,
    input logic rst_n,
    input logic line,
    input logic hostOe,
    input logic devOe,
    input logic powerSwitchEn_r,
    input logic oneWireMode_r,
    input cpdi_pkg::cpdi_level_type levelCode_r,
    input cpdi_pkg::cpdi_mv_type refLevel_r
);
    import cpdi_pkg::*;
    int unsigned lowCnt_r;
    int unsigned ackCnt_r;
    // -------------------------------
    // Run-length counters
    // -------------------------------
    always_ff @(posedge clk) begin
        lowCnt_r <= (!rst_n || line) ? 0 : lowCnt_r + 1;
    end
    always_ff @(posedge clk) begin
        ackCnt_r <= (!rst_n || !devOe) ? 0 : ackCnt_r + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // -------------------------------
    // Properties
    // -------------------------------
    sequence s_ackStart;
        $rose(devOe);
    endsequence
    property p_shut;
        lowCnt_r >= SHUT_CYC + 3 |-> !powerSwitchEn_r;
    endproperty
    property p_noShort;
        $fell(powerSwitchEn_r) |-> lowCnt_r >= SHUT_CYC;
    endproperty
    property p_enable;
        $rose(line) && !powerSwitchEn_r |-> ##[1:3] powerSwitchEn_r;
    endproperty
    property p_freshMode;
        $rose(powerSwitchEn_r) |-> ##[0:2] !oneWireMode_r;
    endproperty
    property p_modeHold;
        powerSwitchEn_r && $past(powerSwitchEn_r) && $past(oneWireMode_r)
            |-> oneWireMode_r;
    endproperty
    property p_ackLen;
        $fell(devOe) |-> ackCnt_r == ACK_CYC;
    endproperty
    property p_ackMax;
        ackCnt_r <= ACK_CYC;
    endproperty
    property p_ackStart;
        s_ackStart |-> oneWireMode_r && !hostOe && $past(line);
    endproperty
    property p_level;
        $changed(levelCode_r) |-> oneWireMode_r && $past(line);
    endproperty
    property p_refMax;
        refLevel_r <= `CPD_FULL_MV;
    endproperty
    a_shut: assert property (p_shut)
        else $error("long low without shutdown");
    a_noShort: assert property (p_noShort)
        else $error("shutdown after short low");
    a_enable: assert property (p_enable)
        else $error("rise did not enable");
    a_freshMode: assert property (p_freshMode)
        else $error("one-wire mode kept over restart");
    a_modeHold: assert property (p_modeHold)
        else $error("mode changed while enabled");
    a_ackLen: assert property (p_ackLen)
        else $error("acknowledge length wrong");
    a_ackMax: assert property (p_ackMax)
        else $error("acknowledge too long");
    a_ackStart: assert property (p_ackStart)
        else $error("acknowledge out of place");
    a_level: assert property (p_level)
        else $error("level changed outside a frame");
    a_refMax: assert property (p_refMax)
        else $error("reference above full scale");
endmodule : cpdi_properties

// file: verification/tb.sv
// Self-checking bench of the control pin link
`timescale 1ns/10ps
`include "cpdi_map.svh"
module tb;
    import cpdi_pkg::*;
    localparam int unsigned DSHUT = 5000;
    localparam int unsigned DACK = 200;
    localparam int unsigned DWIN = 9000, DDET = 1000, DIDLE = 1500;
    localparam int unsigned HWAIT = 4200, HENT = 1500;
    localparam int unsigned HSHUT = 6000, HGAP = 1700;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic powerSwitchEn_r;
    logic oneWireMode_r;
    cpdi_level_type levelCode_r;
    cpdi_mv_type refLevel_r;
    int miscompares = 0;
    int cmp_count = 0;
    int ackRises = 0;
    int nAck;
    logic [31:0] q;
    logic err;
    cpdi_level_type lvl;
    int duty;
    int hi;
    cpdi_if link();
    cpdi_device #(.SHUT_CYC(DSHUT), .WIN_CYC(DWIN), .DETECT_CYC(DDET),
        .ACK_CYC(DACK), .IDLE_CYC(DIDLE)) cpdi_device_inst (.clk(clk),
        .rst_n(rst_n), .link(link), .powerSwitchEn_r(powerSwitchEn_r),
        .oneWireMode_r(oneWireMode_r), .levelCode_r(levelCode_r),
        .refLevel_r(refLevel_r));
    cpdi_host #(.WAIT_CYC(HWAIT), .ENTRY_CYC(HENT), .SHUT_CYC(HSHUT),
        .GAP_CYC(HGAP)) cpdi_host_inst (.clk(clk), .rst_n(rst_n),
        .link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
        .pready_r(pready_r), .pslverr_r(pslverr_r));
    cpdi_properties #(.SHUT_CYC(DSHUT), .ACK_CYC(DACK))
        cpdi_properties_inst (.clk(clk), .rst_n(rst_n), .line(link.line),
        .hostOe(link.hostOe), .devOe(link.devOe),
        .powerSwitchEn_r(powerSwitchEn_r), .oneWireMode_r(oneWireMode_r),
        .levelCode_r(levelCode_r), .refLevel_r(refLevel_r));
    always #12.5 clk = ~clk;
    always @(posedge link.devOe) ackRises++;
    // -------------------------------
    // Expectations and transfers
    // -------------------------------
    function automatic int mvOf(input int c);
        if (c == 0) return 0;
        if (c <= 12) return 5 + 3 * (c - 1);
        if (c <= 23) return 38 + 6 * (c - 12);
        return 104 + 12 * (c - 23);
    endfunction : mvOf
    function automatic logic near(input cpdi_mv_type v, input int e);
        return (v === 8'(e)) || (v === 8'(e + 1)) || (v === 8'(e - 1));
    endfunction : near
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        logic ok;
        n = 0;
        ok = 1'h0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        while (!ok && n < 20) begin
            @(posedge clk);
            ok = (pready_r === 1'h1);
            n++;
        end
        q = prdata_r;
        err = pslverr_r;
        psel <= 1'h0;
        penable <= 1'h0;
        if (!ok) miscompares++;
        @(posedge clk);
    endtask : apb
    task automatic waitIdle();
        int n;
        n = 0;
        repeat (4) @(posedge clk);
        q = 32'h1;
        while (q[0] !== 1'h0 && n < 20000) begin
            apb(1'h0, 12'h008, 32'h0);
            n++;
        end
        if (q[0] !== 1'h0) miscompares++;
    endtask : waitIdle
    task conclude();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // -------------------------------
    // Tests
    // -------------------------------
    initial begin
        void'($urandom(32'hacb1));
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        apb(1'h0, 12'h008, 32'h0);
        chk("status", q & 32'h2f, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk("duty", q, 32'h100);
        apb(1'h0, 12'hffc, 32'h0);
        chk("unmapped err", err, 1'h1);
        chk("unmapped data", q, 32'h0);
        chk("level reset", levelCode_r, 5'h1f);
        chk("switch reset", powerSwitchEn_r, 1'h0);
        apb(1'h1, 12'h000, 32'h3);
        apb(1'h0, 12'h008, 32'h0);
        chk("refused", q[5], 1'h1);
        $display("test registers done");
        apb(1'h1, 12'h000, 32'h2);
        waitIdle();
        chk("mode field", q[3:2], 2'h2);
        chk("one-wire", oneWireMode_r, 1'h1);
        $display("test entry done");
        lvl = 5'($urandom_range(30));
        apb(1'h1, 12'h000, {16'h0, 3'h4, lvl, 8'h03});
        waitIdle();
        repeat (DACK + 1500) @(posedge clk);
        apb(1'h0, 12'h008, 32'h0);
        chk("ack seen", q[1], 1'h1);
        chk("level", levelCode_r, lvl);
        chk("ref", near(refLevel_r, mvOf(lvl)), 1'h1);
        $display("test frame done");
        nAck = ackRises;
        apb(1'h1, 12'h000, {16'h0, 3'h7, ~lvl, 8'h03});
        waitIdle();
        repeat (DACK + 100) @(posedge clk);
        chk("bad sub level", levelCode_r, lvl);
        chk("bad sub ack", ackRises - nAck, 32'h0);
        chk("bad sub seen", q[1], 1'h0);
        $display("test bad frame done");
        apb(1'h1, 12'h000, 32'h4);
        waitIdle();
        chk("switch off", powerSwitchEn_r, 1'h0);
        chk("level kept", levelCode_r, lvl);
        apb(1'h1, 12'h004, 32'h100);
        apb(1'h1, 12'h000, 32'h1);
        repeat (9500) @(posedge clk);
        chk("pwm mode", oneWireMode_r, 1'h0);
        chk("switch on", powerSwitchEn_r, 1'h1);
        chk("pwm ref", near(refLevel_r, 200), 1'h1);
        duty = 1 + $urandom_range(255);
        apb(1'h1, 12'h004, 32'(duty));
        hi = 0;
        repeat (`CPD_PWM_CYC) begin
            @(posedge clk);
            hi += int'(link.line);
        end
        chk("pwm high", hi, `CPD_PWM_CYC * duty / 256);
        apb(1'h1, 12'h000, 32'h3);
        apb(1'h0, 12'h008, 32'h0);
        chk("pwm refused", q[5], 1'h1);
        $display("test pwm done");
        rst_n <= 1'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk("level restored", levelCode_r, 5'h1f);
        $display("test reset done");
        conclude();
    end
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule : tb
